// ---- pkg/lsd_pkg.sv ----
package lsd_pkg;
    localparam int NUM_DRV = 31;
    localparam int NUM_REGS = 31;
    localparam int NUM_PORT = 8;
    localparam int NUM_COM = 4;
    localparam int REG_W = 4;
    localparam int MAP_W = 7;
    localparam int PORT_MAP_W = 3;
    localparam int ADDR_W = 10;
    localparam int IDX_W = 8;
    localparam int IDX_LSB = 2;
    localparam int NUM_BITS = NUM_REGS * REG_W;
    localparam logic [IDX_W-1:0] IDX_CTRL = 8'h1E;
    localparam logic [IDX_W-1:0] IDX_DATA_FIRST = 8'h40;
    localparam logic [IDX_W-1:0] IDX_DATA_LAST = 8'h5E;
    localparam int CTRL_FIXED_BIT = 3;
    localparam int CTRL_BLANK_BIT = 2;
    localparam int CTRL_DUTY_HI = 1;
    localparam int CTRL_DUTY_LO = 0;
    localparam logic [REG_W-1:0] CTRL_RESET = 4'h8;
    localparam logic [REG_W-1:0] DATA_RESET = 4'h0;
    localparam int SLOT_TIME_NS = 7812500;
    localparam int CLK_FREQ_MHZ = 125;
    localparam int NS_PER_US = 1000;
    localparam int SLOT_CYCLES_DEF = (SLOT_TIME_NS * CLK_FREQ_MHZ) / NS_PER_US;

    typedef enum logic [1:0] {
        DUTY_QUARTER = 2'h0,
        DUTY_THIRD = 2'h1,
        DUTY_HALF = 2'h2,
        DUTY_BAD = 2'h3
    } lsd_duty_t;

    typedef enum logic [2:0] {
        LVL_VDD = 3'h0,
        LVL_VSS1 = 3'h1,
        LVL_VSS2 = 3'h2,
        LVL_VSS3 = 3'h3,
        LVL_GND = 3'h4
    } lsd_level_t;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'h0,
        BUS_ACK = 1'h1
    } lsd_bus_state_t;

    typedef struct packed {
        logic fixed;
        logic blank;
        lsd_duty_t duty;
    } lsd_ctrl_t;

    function automatic logic [NUM_DRV-1:0] lsd_default_is_com();
        logic [NUM_DRV-1:0] r;
        r = '0;
        for (int d = NUM_DRV - NUM_COM; d < NUM_DRV; d++) r[d] = 1'b1;
        return r;
    endfunction : lsd_default_is_com

    function automatic logic [NUM_DRV-1:0][1:0] lsd_default_com_sel();
        logic [NUM_DRV-1:0][1:0] r;
        r = '0;
        for (int d = NUM_DRV - NUM_COM; d < NUM_DRV; d++) r[d] = 2'(d - (NUM_DRV - NUM_COM));
        return r;
    endfunction : lsd_default_com_sel

    function automatic logic [NUM_DRV-1:0][NUM_COM-1:0][MAP_W-1:0] lsd_default_seg_map();
        logic [NUM_DRV-1:0][NUM_COM-1:0][MAP_W-1:0] r;
        for (int d = 0; d < NUM_DRV; d++)
            for (int k = 0; k < NUM_COM; k++) r[d][k] = MAP_W'((d * NUM_COM + k) % NUM_BITS);
        return r;
    endfunction : lsd_default_seg_map

    function automatic logic [NUM_PORT-1:0][PORT_MAP_W-1:0] lsd_default_port_map();
        logic [NUM_PORT-1:0][PORT_MAP_W-1:0] r;
        for (int p = 0; p < NUM_PORT; p++) r[p] = PORT_MAP_W'(p);
        return r;
    endfunction : lsd_default_port_map
endpackage : lsd_pkg

// ---- hw/lsd_lcd_driver.sv ----
// Summary of operation
// - Thirty-one driver outputs, each built as segment or common driver.
// - Software picks quarter, third or half duty through the duty field.
// - Reset clears both duty bits, giving quarter duty.
// - Control bit 2 blanks the panel; it resets to zero, normal drive.
// - While blanked every display driver output sits at the positive supply.
// - Blanking or unblanking leaves all display data unchanged.
// - Blanking does not touch pins built as output ports.
// - Thirty-one four-bit data registers at consecutive addresses 40H to 5EH.
// - Reset clears every display data bit, so all segments are dark.
// - Data bit one lights its segment, zero leaves it dark.
// - Segment drivers use four, three or two mapped bits per duty.
// - Bit to driver mapping is fixed at build time by parameters.
// - Half duty uses half bias; quarter and third duty use third bias.
// - Pins zero to seven can each be built as a plain output port.
// - A port pin follows one data bit, high to supply, low to ground.
// - Only the first two data registers can feed port pins.
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/10ps
module lsd_lcd_driver #(
    parameter int SLOT_CYCLES = lsd_pkg::SLOT_CYCLES_DEF,
    parameter logic [lsd_pkg::NUM_DRV-1:0] DRV_IS_COM = lsd_pkg::lsd_default_is_com(),
    parameter logic [lsd_pkg::NUM_DRV-1:0][1:0] DRV_COM_SEL = lsd_pkg::lsd_default_com_sel(),
    parameter logic [lsd_pkg::NUM_DRV-1:0][lsd_pkg::NUM_COM-1:0][lsd_pkg::MAP_W-1:0] DRV_MAP =
        lsd_pkg::lsd_default_seg_map(),
    parameter logic [lsd_pkg::NUM_PORT-1:0] PORT_EN = 8'h00,
    parameter logic [lsd_pkg::NUM_PORT-1:0][lsd_pkg::PORT_MAP_W-1:0] PORT_MAP =
        lsd_pkg::lsd_default_port_map()
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic [lsd_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output lsd_pkg::lsd_level_t [lsd_pkg::NUM_DRV-1:0] drv_level,
    output logic [1:0] com_slot,
    output logic frame_phase
);
    import lsd_pkg::*;

    localparam int CNT_W = $clog2(SLOT_CYCLES + 1);

    lsd_ctrl_t panel_control;
    logic [REG_W-1:0] segment_data_registers [NUM_REGS];
    logic [NUM_BITS-1:0] data_bits;
    logic [2*REG_W-1:0] port_bits;
    lsd_bus_state_t bus_state;
    logic [CNT_W-1:0] slot_cnt;
    logic [1:0] slot;
    logic phase;
    logic [2:0] commons;
    logic [IDX_W-1:0] idx;
    logic req;
    logic acc_wr;
    logic half_bias;
    lsd_level_t next_level [NUM_DRV];

    // Decoded number of common lines in a frame; the forbidden code falls back to quarter.
    function automatic logic [2:0] lsd_commons(input lsd_duty_t duty);
        case (duty)
            DUTY_THIRD: return 3'h3;
            DUTY_HALF: return 3'h2;
            default: return 3'h4;
        endcase
    endfunction : lsd_commons

    function automatic logic lsd_is_data(input logic [IDX_W-1:0] a);
        return (a >= IDX_DATA_FIRST) && (a <= IDX_DATA_LAST);
    endfunction : lsd_is_data

    // Common level: selected swings full scale, unselected sits at an inner level.
    function automatic lsd_level_t lsd_com_level(input logic sel, input logic ph,
                                                 input logic half);
        if (sel)
            return ph ? LVL_VDD : (half ? LVL_VSS2 : LVL_VSS3);
        else if (half)
            return LVL_VSS1;
        else
            return ph ? LVL_VSS2 : LVL_VSS1;
    endfunction : lsd_com_level

    // Segment level sits opposite the selected common when lit; when dark, beside it under third bias and at it under half bias.
    function automatic lsd_level_t lsd_seg_level(input logic on, input logic ph,
                                                 input logic half);
        if (on)
            return ph ? (half ? LVL_VSS2 : LVL_VSS3) : LVL_VDD;
        else if (half)
            return ph ? LVL_VDD : LVL_VSS2;
        else
            return ph ? LVL_VSS1 : LVL_VSS2;
    endfunction : lsd_seg_level

    function automatic logic lsd_get_bit(input logic [NUM_BITS-1:0] bits,
                                         input logic [MAP_W-1:0] pos);
        return (int'(pos) < NUM_BITS) ? bits[pos] : 1'b0;
    endfunction : lsd_get_bit

    assign idx = avs_address[ADDR_W-1:IDX_LSB];
    assign req = avs_read || avs_write;
    assign acc_wr = avs_write && (bus_state == BUS_ACK) && avs_byteenable[0];
    assign commons = lsd_commons(panel_control.duty);
    assign half_bias = (panel_control.duty == DUTY_HALF);

    always_comb
    begin
        for (int r = 0; r < NUM_REGS; r++) data_bits[r*REG_W +: REG_W] = segment_data_registers[r];
        port_bits = {segment_data_registers[1], segment_data_registers[0]};
    end

    // One wait cycle per access: read data is loaded with the first cycle and stands when
    // waitrequest drops, so the master samples it on the same edge the write lands.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            bus_state <= BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end
        else if (ce)
        begin
            case (bus_state)
                BUS_IDLE:
                begin
                    if (req)
                    begin
                        bus_state <= BUS_ACK;
                        avs_waitrequest <= 1'b0;
                        avs_readdata <= 32'h0000_0000;
                        if (avs_read && (idx == IDX_CTRL))
                            avs_readdata[REG_W-1:0] <= panel_control;
                        else if (avs_read && lsd_is_data(idx))
                            avs_readdata[REG_W-1:0] <=
                                segment_data_registers[int'(idx - IDX_DATA_FIRST)];
                    end
                end
                BUS_ACK:
                begin
                    bus_state <= BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default:
                begin
                    bus_state <= BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // The top control bit is fixed at one; writes never reach it.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            panel_control <= CTRL_RESET;
        else if (ce && acc_wr && (idx == IDX_CTRL))
        begin
            panel_control.blank <= avs_writedata[CTRL_BLANK_BIT];
            panel_control.duty <= lsd_duty_t'(avs_writedata[CTRL_DUTY_HI:CTRL_DUTY_LO]);
        end
    end

    // Only a data address writes here, so blanking never disturbs stored segments.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            for (int r = 0; r < NUM_REGS; r++) segment_data_registers[r] <= DATA_RESET;
        end
        else if (ce && acc_wr && lsd_is_data(idx))
            segment_data_registers[int'(idx - IDX_DATA_FIRST)] <= avs_writedata[REG_W-1:0];
    end

    // Slot timer: one common per slot, polarity turns over at the end of every frame
    // so the glass never sees a DC component.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            slot_cnt <= '0;
            slot <= 2'h0;
            phase <= 1'b0;
        end
        else if (ce)
        begin
            if ({1'b0, slot} >= commons)
            begin
                slot <= 2'h0;
                slot_cnt <= '0;
            end
            else if (slot_cnt == CNT_W'(SLOT_CYCLES - 1))
            begin
                slot_cnt <= '0;
                if ({1'b0, slot} == commons - 3'h1)
                begin
                    slot <= 2'h0;
                    phase <= ~phase;
                end
                else
                    slot <= slot + 2'h1;
            end
            else
                slot_cnt <= slot_cnt + CNT_W'(1);
        end
    end

    always_comb
    begin
        for (int d = 0; d < NUM_DRV; d++)
        begin
            if ((d < NUM_PORT) && PORT_EN[d])
                next_level[d] = port_bits[PORT_MAP[d]] ? LVL_VDD : LVL_GND;
            else if (panel_control.blank)
                next_level[d] = LVL_VDD;
            else if (DRV_IS_COM[d])
                next_level[d] = lsd_com_level(({1'b0, DRV_COM_SEL[d]} < commons)
                    && (DRV_COM_SEL[d] == slot), phase, half_bias);
            else
                next_level[d] = lsd_seg_level(lsd_get_bit(data_bits, DRV_MAP[d][slot]),
                    phase, half_bias);
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            for (int d = 0; d < NUM_DRV; d++) drv_level[d] <= LVL_VDD;
            com_slot <= 2'h0;
            frame_phase <= 1'b0;
        end
        else if (ce)
        begin
            for (int d = 0; d < NUM_DRV; d++) drv_level[d] <= next_level[d];
            com_slot <= slot;
            frame_phase <= phase;
        end
    end

    sequence s_req_open;
        ce && req && (bus_state == BUS_IDLE);
    endsequence

    sequence s_ack;
        ce && !avs_waitrequest;
    endsequence

    property p_bus_answer;
        @(posedge clk_sys) disable iff (rst)
        s_req_open |=> s_ack ##1 avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer not one cycle");

    property p_data_write;
        @(posedge clk_sys) disable iff (rst)
        (ce && acc_wr && (idx == IDX_DATA_FIRST)) |=>
            (segment_data_registers[0] == $past(avs_writedata[REG_W-1:0]));
    endproperty
    a_data_write: assert property (p_data_write) else $error("data write lost");

    property p_ctrl_keeps_data;
        @(posedge clk_sys) disable iff (rst)
        (ce && acc_wr && (idx == IDX_CTRL)) |=> $stable(data_bits);
    endproperty
    a_ctrl_keeps_data: assert property (p_ctrl_keeps_data) else $error("data changed");

    // Driver NUM_PORT is the first one that can never be built as a port pin, so
    // blanking and segment drive always reach it whatever the port options are.
    property p_blank_vdd;
        @(posedge clk_sys) disable iff (rst)
        (ce && panel_control.blank && !DRV_IS_COM[NUM_PORT]) |=>
            (drv_level[NUM_PORT] == LVL_VDD);
    endproperty
    a_blank_vdd: assert property (p_blank_vdd) else $error("blanked driver not at supply");

    property p_blank_com;
        @(posedge clk_sys) disable iff (rst)
        (ce && panel_control.blank) |=> (drv_level[NUM_DRV-1] == LVL_VDD);
    endproperty
    a_blank_com: assert property (p_blank_com) else $error("blanked common not at supply");

    property p_slot_range;
        @(posedge clk_sys) disable iff (rst)
        (ce && $stable(panel_control.duty)) |-> ({1'b0, slot} < commons);
    endproperty
    a_slot_range: assert property (p_slot_range) else $error("slot beyond active commons");

    property p_duty_decode;
        @(posedge clk_sys) disable iff (rst)
        (panel_control.duty == DUTY_HALF) |-> (commons == 3'h2) && half_bias;
    endproperty
    a_duty_decode: assert property (p_duty_decode) else $error("half duty decode wrong");

    property p_seg_on;
        @(posedge clk_sys) disable iff (rst)
        (ce && !panel_control.blank && !DRV_IS_COM[NUM_PORT] && !half_bias
            && lsd_get_bit(data_bits, DRV_MAP[NUM_PORT][slot]) && !phase)
            |=> (drv_level[NUM_PORT] == LVL_VDD);
    endproperty
    a_seg_on: assert property (p_seg_on) else $error("lit segment level wrong");

    property p_seg_dark;
        @(posedge clk_sys) disable iff (rst)
        (ce && !panel_control.blank && !DRV_IS_COM[NUM_PORT] && !half_bias
            && !lsd_get_bit(data_bits, DRV_MAP[NUM_PORT][slot]) && !phase)
            |=> (drv_level[NUM_PORT] == LVL_VSS2);
    endproperty
    a_seg_dark: assert property (p_seg_dark) else $error("dark segment wrong");

    property p_com_select;
        @(posedge clk_sys) disable iff (rst)
        (ce && !panel_control.blank && DRV_IS_COM[NUM_DRV-1] && phase
            && ({1'b0, DRV_COM_SEL[NUM_DRV-1]} < commons) && (DRV_COM_SEL[NUM_DRV-1] == slot))
            |=> (drv_level[NUM_DRV-1] == LVL_VDD);
    endproperty
    a_com_select: assert property (p_com_select) else $error("common level off");

    // Half bias has no third inner level, so the lowest rail must never appear.
    property p_half_bias;
        @(posedge clk_sys) disable iff (rst)
        (ce && half_bias) |=>
            (drv_level[NUM_DRV-1] != LVL_VSS3) && (drv_level[NUM_PORT] != LVL_VSS3);
    endproperty
    a_half_bias: assert property (p_half_bias) else $error("bias level wrong");

    property p_ctrl_write;
        @(posedge clk_sys) disable iff (rst)
        (ce && acc_wr && (idx == IDX_CTRL)) |=>
            (panel_control.duty == $past(avs_writedata[CTRL_DUTY_HI:CTRL_DUTY_LO]))
            && (panel_control.blank == $past(avs_writedata[CTRL_BLANK_BIT]))
            && panel_control.fixed;
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("control write lost");

    generate
        for (genvar p = 0; p < NUM_PORT; p++)
        begin : g_port_chk
            if (PORT_EN[p])
            begin : g_on
                property p_port_follow;
                    @(posedge clk_sys) disable iff (rst)
                    ce |=> (drv_level[p] == ($past(port_bits[PORT_MAP[p]]) ? LVL_VDD : LVL_GND));
                endproperty
                a_port_follow: assert property (p_port_follow) else $error("port pin wrong");
            end
        end
    endgenerate
endmodule : lsd_lcd_driver

// ---- tb/lsd_lcd_panel.sv ----
`timescale 1ns/10ps
module lsd_lcd_panel #(
    parameter logic [lsd_pkg::NUM_DRV-1:0] IS_COM = lsd_pkg::lsd_default_is_com(),
    parameter logic [lsd_pkg::NUM_DRV-1:0][1:0] COM_SEL = lsd_pkg::lsd_default_com_sel(),
    parameter logic [lsd_pkg::NUM_DRV-1:0] OFF_GLASS = 31'h0
) (
    input wire logic clk_sys,
    input wire logic clear,
    input wire lsd_pkg::lsd_level_t [lsd_pkg::NUM_DRV-1:0] drv_level,
    output logic [lsd_pkg::NUM_DRV-1:0][lsd_pkg::NUM_COM-1:0] lit
);
    import lsd_pkg::*;

    function automatic int swing(input lsd_level_t a, input lsd_level_t b);
        return (a > b) ? int'(a) - int'(b) : int'(b) - int'(a);
    endfunction : swing

    // A pixel fades slowly, so it counts as lit once a full swing has crossed it since clear.
    // A swing of two or more parts select from non-select under both bias schemes.
    always_ff @(posedge clk_sys)
    begin
        if (clear)
        begin
            lit <= '0;
        end
        else
        begin
            for (int s = 0; s < NUM_DRV; s++)
                for (int c = 0; c < NUM_DRV; c++)
                    if (IS_COM[c] && !IS_COM[s] && !OFF_GLASS[s]
                        && swing(drv_level[s], drv_level[c]) >= 2)
                        lit[s][COM_SEL[c]] <= 1'b1;
        end
    end
endmodule : lsd_lcd_panel

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
    import lsd_pkg::*;
    localparam int SLOT = 4;
    localparam logic [NUM_PORT-1:0] PORTS = 8'h03;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    lsd_level_t [NUM_DRV-1:0] drv_level;
    logic [1:0] com_slot;
    logic frame_phase;
    logic clear = 1'b0;
    logic [NUM_DRV-1:0][NUM_COM-1:0] lit;
    logic [REG_W-1:0] shadow [NUM_REGS] = '{default: '0};
    int n_fail = 0;
    int comparisons = 0;

    always #4 clk_sys = ~clk_sys;

    lsd_lcd_driver #(.SLOT_CYCLES(SLOT), .PORT_EN(PORTS)) u_lsd_lcd_driver (
        .clk_sys(clk_sys), .rst(rst), .ce(ce), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .drv_level(drv_level), .com_slot(com_slot),
        .frame_phase(frame_phase)
    );

    // Port pins are not wired to the glass, so the panel ignores them.
    lsd_lcd_panel #(.OFF_GLASS(NUM_DRV'(PORTS))) u_lsd_lcd_panel (
        .clk_sys(clk_sys), .clear(clear), .drv_level(drv_level), .lit(lit)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic bus(input logic wr, input logic [IDX_W-1:0] idx, input logic [3:0] d,
                       input logic [3:0] be, output logic [31:0] rd);
        @(posedge clk_sys);
        avs_address <= {idx, 2'h0};
        avs_writedata <= {28'h0, d};
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= ~wr;
        do
        begin
            @(posedge clk_sys);
        end
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task automatic wr(input logic [IDX_W-1:0] idx, input logic [3:0] d);
        logic [31:0] rd;
        bus(1'b1, idx, d, 4'hF, rd);
    endtask : wr

    task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [3:0] exp);
        logic [31:0] rd;
        bus(1'b0, idx, 4'h0, 4'hF, rd);
        check(rd, {28'h0, exp});
    endtask : rd_chk

    task automatic settle();
        repeat (2) @(negedge clk_sys);
    endtask : settle

    // The glass is cleared only after the new state reaches the drivers, else stale levels count.
    task automatic panel_check(input int ncom);
        @(posedge clk_sys);
        clear <= 1'b1;
        @(posedge clk_sys);
        clear <= 1'b0;
        repeat (3 * NUM_COM * SLOT)
        begin
            @(negedge clk_sys);
            check(32'(com_slot < ncom), 32'h1);
            check(32'(ncom == 2 && drv_level[NUM_DRV-NUM_COM] == LVL_VSS3), 32'h0);
        end
        for (int d = 2; d < NUM_DRV - NUM_COM; d++)
            for (int k = 0; k < NUM_COM; k++)
                check(32'(lit[d][k]), 32'(k < ncom && shadow[d][k]));
    endtask : panel_check

    task automatic test_reset();
        rd_chk(IDX_CTRL, CTRL_RESET);
        for (int i = 0; i < NUM_REGS; i++)
            rd_chk(IDX_DATA_FIRST + IDX_W'(i), DATA_RESET);
        panel_check(4);
        $display("test reset done");
    endtask : test_reset

    task automatic test_regs();
        logic [31:0] rd;
        for (int i = 0; i < NUM_REGS; i++)
        begin
            shadow[i] = 4'(i + 3);
            wr(IDX_DATA_FIRST + IDX_W'(i), shadow[i]);
        end
        for (int i = 0; i < NUM_REGS; i++)
            rd_chk(IDX_DATA_FIRST + IDX_W'(i), shadow[i]);
        wr(IDX_DATA_LAST + 8'h01, 4'hF);
        rd_chk(IDX_DATA_LAST + 8'h01, 4'h0);
        rd_chk(IDX_DATA_FIRST - 8'h01, 4'h0);
        bus(1'b1, IDX_DATA_FIRST, 4'hA, 4'hE, rd);
        rd_chk(IDX_DATA_FIRST, shadow[0]);
        $display("test regs done");
    endtask : test_regs

    task automatic test_duty();
        lsd_duty_t modes [3] = '{DUTY_QUARTER, DUTY_THIRD, DUTY_HALF};
        int ncom [3] = '{4, 3, 2};
        for (int m = 0; m < 3; m++)
        begin
            wr(IDX_CTRL, {2'h0, modes[m]});
            rd_chk(IDX_CTRL, {2'h2, modes[m]});
            panel_check(ncom[m]);
        end
        $display("test duty done");
    endtask : test_duty

    task automatic test_blank();
        wr(IDX_DATA_FIRST, 4'h1);
        shadow[0] = 4'h1;
        wr(IDX_CTRL, 4'h4);
        settle();
        repeat (2 * NUM_COM * SLOT)
        begin
            @(negedge clk_sys);
            for (int d = 2; d < NUM_DRV; d++)
                check(32'(drv_level[d]), 32'(LVL_VDD));
        end
        check(32'(drv_level[0]), 32'(LVL_VDD));
        check(32'(drv_level[1]), 32'(LVL_GND));
        wr(IDX_DATA_FIRST, 4'h2);
        shadow[0] = 4'h2;
        settle();
        check(32'(drv_level[0]), 32'(LVL_GND));
        check(32'(drv_level[1]), 32'(LVL_VDD));
        for (int i = 0; i < NUM_REGS; i++)
            rd_chk(IDX_DATA_FIRST + IDX_W'(i), shadow[i]);
        wr(IDX_CTRL, 4'h0);
        panel_check(4);
        $display("test blank done");
    endtask : test_blank

    // Quarter duty is left set by test_blank, so one frame later the slot repeats and the polarity has turned.
    task automatic test_hold();
        logic [1:0] s;
        logic p;
        @(posedge clk_sys);
        ce <= 1'b0;
        @(negedge clk_sys);
        s = com_slot;
        p = frame_phase;
        repeat (2 * NUM_COM * SLOT)
        begin
            @(negedge clk_sys);
            check(32'(com_slot), 32'(s));
            check(32'(frame_phase), 32'(p));
            check(32'(avs_waitrequest), 32'h1);
        end
        @(posedge clk_sys);
        ce <= 1'b1;
        @(negedge clk_sys);
        s = com_slot;
        p = frame_phase;
        repeat (NUM_COM * SLOT) @(negedge clk_sys);
        check(32'(com_slot), 32'(s));
        check(32'(frame_phase), 32'(!p));
        $display("test hold done");
    endtask : test_hold

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    initial
    begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        test_reset();
        test_regs();
        test_duty();
        test_blank();
        test_hold();
        complete_run();
    end

    // Whole run needs under a thousand cycles; this margin only cuts a hang short.
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        complete_run();
    end
endmodule : tb_top
